// ### design/i2c_slave_core.sv
`timescale 1ns/10ps
module i2c_slave_core #(
  parameter int unsigned RX_DEPTH = i2cs_pkg::RX_DEPTH_DEF
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [15:0] control_reg_in,
  input wire logic [9:0] own_address_reg_in,
  input wire i2cs_pkg::byte_req_s transmit_write_in,
  input wire logic clock_line_release_in,
  input wire logic overflow_clear_in,
  output i2cs_pkg::byte_req_s receive_byte_out,
  input wire logic receive_ready_in,
  output logic [15:0] status_reg_out,
  output logic slave_event_flag_out
);
  import i2cs_pkg::*;

  typedef struct packed {
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    slv_state_e st;
    slv_state_e after;
    logic [3:0] cnt;
    logic [7:0] receive_shift_reg;
    logic [7:0] tx_shift;
    logic [7:0] transmit_byte_reg;
    logic tx_full;
    logic hold;
    logic sda_drv;
    logic ack;
    logic rw;
    logic evt_pend;
    logic evt;
    logic receive_overflow_flag;
    logic ten_bit_match_flag;
  } core_s;

  core_s r;
  core_s n;
  logic module_enable_bit;
  logic ten_bit_address_select;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic live;
  logic busy;
  logic push;
  logic rx_in_ready;
  logic rx_out_valid;
  logic [7:0] rx_out_data;
  logic hdr_hit;
  logic hit7;
  logic hit8;

  assign module_enable_bit = control_reg_in[CTRL_ENABLE_POS];
  assign ten_bit_address_select = control_reg_in[CTRL_TEN_BIT_POS];

  // only stages 1 and 2 of each synchroniser feed logic
  assign scl_rise = r.scl_sy[1] & ~r.scl_sy[2];
  assign scl_fall = ~r.scl_sy[1] & r.scl_sy[2];
  assign start_seen = r.scl_sy[1] & r.scl_sy[2] & ~r.sda_sy[1] & r.sda_sy[2];
  assign stop_seen = r.scl_sy[1] & r.scl_sy[2] & r.sda_sy[1] & ~r.sda_sy[2];
  assign busy = (r.st != ST_IDLE) && (r.st != ST_WAIT);
  assign live = module_enable_bit & ~start_seen & ~stop_seen & ~r.hold;

  assign hit7 = (r.receive_shift_reg[7:1] == own_address_reg_in[6:0]);
  assign hdr_hit = (r.receive_shift_reg[7:3] == TEN_BIT_HEADER) &&
                   (r.receive_shift_reg[2:1] == own_address_reg_in[9:8]);
  assign hit8 = (r.receive_shift_reg == own_address_reg_in[7:0]);

  rx_pair_buffer #(
    .W(8),
    .DEPTH(RX_DEPTH)
  ) u_rx_buf (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(push),
    .in_ready_out(rx_in_ready),
    .in_data_in(r.receive_shift_reg),
    .out_valid_out(rx_out_valid),
    .out_ready_in(receive_ready_in),
    .out_data_out(rx_out_data)
  );

  always_comb begin
    n = r;
    push = 1'b0;
    n.scl_sy = {r.scl_sy[1:0], scl_in};
    n.sda_sy = {r.sda_sy[1:0], sda_in};
    n.evt = 1'b0;
    if (overflow_clear_in) begin
      n.receive_overflow_flag = 1'b0;
    end
    if (!module_enable_bit || stop_seen) begin
      n.st = ST_IDLE;
      n.cnt = '0;
      n.sda_drv = 1'b0;
      n.hold = 1'b0;
    end else if (start_seen) begin
      n.st = ST_ADDR;
      n.cnt = '0;
      n.sda_drv = 1'b0;
      n.hold = 1'b0;
    end else if (busy && r.hold) begin
      if (clock_line_release_in) begin
        // the clock is still low here, so the first bit settles early
        n.hold = 1'b0;
        n.tx_shift = r.transmit_byte_reg;
        n.sda_drv = ~r.transmit_byte_reg[7];
        n.tx_full = 1'b0;
      end
    end else if (busy && scl_rise) begin
      n.cnt = r.cnt + 1'b1;
      if (r.cnt < BIT_LAST_DATA) begin
        n.receive_shift_reg = {r.receive_shift_reg[6:0], r.sda_sy[1]};
      end else if (r.st == ST_TX) begin
        n.ack = ~r.sda_sy[1];
      end
    end else if (busy && scl_fall) begin
      if (r.cnt == BIT_LAST_DATA) begin
        n.evt_pend = 1'b0;
        n.ack = 1'b0;
        n.after = ST_WAIT;
        unique case (r.st)
          ST_ADDR: begin
            n.rw = r.receive_shift_reg[0];
            if (!ten_bit_address_select) begin
              n.ack = hit7;
              n.evt_pend = hit7;
              if (hit7) begin
                n.after = r.receive_shift_reg[0] ? ST_TX : ST_RX;
              end
            end else if (hdr_hit && !r.receive_shift_reg[0]) begin
              n.ack = 1'b1;
              n.evt_pend = 1'b1;
              n.ten_bit_match_flag = 1'b0;
              n.after = ST_ADDR2;
            end else if (hdr_hit && r.ten_bit_match_flag) begin
              n.ack = 1'b1;
              n.evt_pend = 1'b1;
              n.after = ST_TX;
            end else begin
              n.ten_bit_match_flag = 1'b0;
            end
          end
          ST_ADDR2: begin
            n.ack = hit8;
            n.evt_pend = hit8;
            n.ten_bit_match_flag = hit8;
            n.after = hit8 ? ST_RX : ST_WAIT;
          end
          ST_RX: begin
            // buffer full means no room: byte dropped, overflow flagged
            push = rx_in_ready;
            n.ack = rx_in_ready & ~r.receive_overflow_flag;
            if (!rx_in_ready) begin
              n.receive_overflow_flag = 1'b1;
            end
            n.evt_pend = 1'b1;
            n.after = ST_RX;
          end
          ST_TX: begin
            n.ack = r.ack;
            n.evt_pend = 1'b1;
            n.after = ST_TX;
          end
          default: begin
            n.after = ST_WAIT;
          end
        endcase
        n.sda_drv = (r.st == ST_TX) ? 1'b0 : n.ack;
      end else if (r.cnt == BIT_ACK) begin
        n.cnt = '0;
        n.sda_drv = 1'b0;
        n.evt = r.evt_pend;
        n.evt_pend = 1'b0;
        n.st = r.after;
        if (r.st == ST_TX && !r.ack) begin
          n.st = ST_WAIT;
        end
        if (n.st == ST_TX) begin
          if (r.tx_full) begin
            n.tx_shift = r.transmit_byte_reg;
            n.sda_drv = ~r.transmit_byte_reg[7];
            n.tx_full = 1'b0;
          end else begin
            n.hold = 1'b1;
          end
        end
      end else if (r.st == ST_TX) begin
        n.tx_shift = {r.tx_shift[6:0], 1'b1};
        n.sda_drv = ~r.tx_shift[6];
      end
    end
    // a single holding stage; a fresh write outranks the load above
    if (transmit_write_in.valid) begin
      n.transmit_byte_reg = transmit_write_in.data;
      n.tx_full = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      r <= '{scl_sy: 3'h7, sda_sy: 3'h7, st: ST_IDLE, after: ST_IDLE,
             cnt: 4'h0, receive_shift_reg: BYTE_RESET,
             tx_shift: BYTE_RESET, transmit_byte_reg: BYTE_RESET,
             default: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = r.hold;
  assign sda_oe_out = r.sda_drv;
  assign slave_event_flag_out = r.evt;
  assign receive_byte_out = '{valid: rx_out_valid, data: rx_out_data};

  always_comb begin
    status_reg_out = '0;
    status_reg_out[STAT_RBF_POS] = ~rx_in_ready;
    status_reg_out[STAT_TBF_POS] = r.tx_full;
    status_reg_out[STAT_RW_POS] = r.rw;
    status_reg_out[STAT_TEN_POS] = r.ten_bit_match_flag;
    status_reg_out[STAT_OVF_POS] = r.receive_overflow_flag;
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_byte_done(slv_state_e s);
    live && busy && scl_fall && r.cnt == BIT_LAST_DATA && r.st == s;
  endsequence

  sequence s_ninth_fall;
    live && busy && scl_fall && r.cnt == BIT_ACK;
  endsequence

  a_idle_wait_start: assert property (
    r.st == ST_IDLE && !start_seen |=> r.st == ST_IDLE)
    else $error("left idle without a start");

  a_rise_shift_in: assert property (
    live && busy && scl_rise && r.cnt < BIT_LAST_DATA |=>
    r.receive_shift_reg == {$past(r.receive_shift_reg[6:0]),
                            $past(r.sda_sy[1])})
    else $error("bit not shifted on clock rise");

  a_seven_bit_ack: assert property (
    s_byte_done(ST_ADDR) ##0 (!ten_bit_address_select && hit7) |=>
    r.ack && sda_oe_out ##0 r.evt_pend)
    else $error("seven-bit match not acknowledged");

  a_seven_bit_miss: assert property (
    s_byte_done(ST_ADDR) ##0 (!ten_bit_address_select && !hit7) |=>
    !sda_oe_out && r.after == ST_WAIT)
    else $error("seven-bit mismatch answered");

  a_ten_hdr_check: assert property (
    s_byte_done(ST_ADDR) ##0 (ten_bit_address_select && !hdr_hit) |=>
    !r.ack && !r.ten_bit_match_flag)
    else $error("bad ten-bit header accepted");

  a_event_at_ninth: assert property (
    slave_event_flag_out |->
    $past(scl_fall) && $past(r.cnt) == BIT_ACK && !$past(slave_event_flag_out))
    else $error("event outside ninth falling edge");

  a_addr_no_push: assert property (
    s_byte_done(ST_ADDR) |-> !push)
    else $error("address byte reached receive buffer");

  a_tx_stretch: assert property (
    s_ninth_fall ##0 (r.after == ST_TX && r.st == ST_ADDR && !r.tx_full) |=>
    scl_oe_out && r.st == ST_TX)
    else $error("clock not held for transmit byte");

  a_tx_sda_stable: assert property (
    r.st == ST_TX && $past(r.st) == ST_TX && r.scl_sy[1] && r.scl_sy[2] |->
    $stable(sda_oe_out))
    else $error("data changed while clock high");

  a_full_nack: assert property (
    s_byte_done(ST_RX) ##0 !rx_in_ready |-> !push ##1
    (!r.ack && !sda_oe_out && r.receive_overflow_flag))
    else $error("full buffer handled wrongly");

  a_ovf_nack: assert property (
    s_byte_done(ST_RX) ##0 (rx_in_ready && r.receive_overflow_flag) |->
    push ##1 !r.ack)
    else $error("overflow byte not loaded with nack");

  a_tx_event: assert property (
    s_ninth_fall ##0 r.st == ST_TX |=> slave_event_flag_out)
    else $error("no event after transmitted byte");
endmodule

// ### design/i2cs_pkg.sv
package i2cs_pkg;

  // control word bit positions
  localparam int unsigned CTRL_ENABLE_POS = 15;
  localparam int unsigned CTRL_TEN_BIT_POS = 10;

  // status word bit positions; bits 3:0 are hardware-owned
  localparam int unsigned STAT_RBF_POS = 0;
  localparam int unsigned STAT_TBF_POS = 1;
  localparam int unsigned STAT_RW_POS = 2;
  localparam int unsigned STAT_TEN_POS = 3;
  localparam int unsigned STAT_OVF_POS = 6;

  // first byte of a ten-bit address (0x78-0x7b as 7-bit values)
  localparam logic [4:0] TEN_BIT_HEADER = 5'h1e;
  localparam logic [3:0] BIT_LAST_DATA = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;
  localparam int unsigned RX_DEPTH_DEF = 2;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR2,
    ST_RX,
    ST_TX,
    ST_WAIT
  } slv_state_e;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_req_s;

endpackage

// ### design/rx_pair_buffer.sv
`timescale 1ns/10ps
module rx_pair_buffer #(
  parameter int unsigned W = 8,
  parameter int unsigned DEPTH = 2
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } buf_s;

  buf_s r;
  buf_s n;
  logic push;
  logic pop;

  assign in_ready_out = (r.cnt != FULL);
  assign out_valid_out = (r.cnt != '0);
  assign out_data_out = r.mem[r.rp];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_data_in;
      n.wp = (r.wp == LAST) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (r.rp == LAST) ? '0 : r.rp + 1'b1;
    end
    if (push && !pop) begin
      n.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      n.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

// ### verif/i2c_bus_master_model.sv
`timescale 1ns/10ps
module i2c_bus_master_model (
  input wire logic clk_sys_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_low_out,
  output logic sda_low_out
);
  logic unstable_seen;
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
    unstable_seen = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  // low half and high half of four cycles each, a 320 ns bus clock
  task automatic bit_io(input logic b, output logic r);
    logic first;
    tick(2);
    sda_low_out = ~b;
    tick(2);
    scl_low_out = 1'b0;
    // the slave may hold the clock low; give up after a bounded wait
    for (int i = 0; i < 500 && scl_in !== 1'b1; i++) tick(1);
    first = sda_in;
    tick(4);
    r = sda_in;
    if (r !== first) unstable_seen = 1'b1;
    scl_low_out = 1'b1;
  endtask
  task automatic start_cond();
    tick(2);
    sda_low_out = 1'b0;
    tick(2);
    scl_low_out = 1'b0;
    tick(4);
    sda_low_out = 1'b1;
    tick(4);
    scl_low_out = 1'b1;
  endtask
  task automatic stop_cond();
    tick(2);
    sda_low_out = 1'b1;
    tick(2);
    scl_low_out = 1'b0;
    tick(4);
    sda_low_out = 1'b0;
    tick(4);
  endtask
  task automatic write_byte(input logic [7:0] d, output logic acked);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    acked = ~r;
  endtask
  task automatic read_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule

// ### verif/i2c_slave_address_and_transfer_tb.sv
`timescale 1ns/10ps
module i2c_slave_address_and_transfer_tb;
  import i2cs_pkg::*;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [15:0] control_reg_in = 16'h8000;
  logic [9:0] own_address_reg_in = 10'h052;
  byte_req_s transmit_write_in = '0;
  logic clock_line_release_in = 1'b0;
  logic overflow_clear_in = 1'b0;
  logic receive_ready_in = 1'b0;
  byte_req_s receive_byte_out;
  logic [15:0] status_reg_out;
  logic slave_event_flag_out, scl_oe_out, sda_oe_out;
  logic scl_out, sda_out;
  logic m_scl_low, m_sda_low, scl_wire, sda_wire;
  int miscompares = 0;
  int samples_checked = 0;
  int events = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  // open drain with pull-ups: any party pulling low wins
  assign scl_wire = ~m_scl_low & (scl_oe_out ? scl_out : 1'b1);
  assign sda_wire = ~m_sda_low & (sda_oe_out ? sda_out : 1'b1);
  // counted between edges, where the pulse stands settled
  always @(negedge clk_sys_in) if (slave_event_flag_out === 1'b1) events++;
  i2c_slave_core i2c_slave_core_i (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .scl_in(scl_wire), .scl_out(scl_out),
    .scl_oe_out(scl_oe_out), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .control_reg_in(control_reg_in),
    .own_address_reg_in(own_address_reg_in),
    .transmit_write_in(transmit_write_in),
    .clock_line_release_in(clock_line_release_in),
    .overflow_clear_in(overflow_clear_in),
    .receive_byte_out(receive_byte_out),
    .receive_ready_in(receive_ready_in), .status_reg_out(status_reg_out),
    .slave_event_flag_out(slave_event_flag_out));
  i2c_bus_master_model i2c_bus_master_model_i (.clk_sys_in(clk_sys_in),
    .scl_in(scl_wire), .sda_in(sda_wire), .scl_low_out(m_scl_low),
    .sda_low_out(m_sda_low));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    check_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  // one byte from the master, then ack and event count after the ninth fall
  task automatic send(input logic [7:0] d, input logic ack, input int ev);
    int e0;
    logic a;
    e0 = events;
    i2c_bus_master_model_i.write_byte(d, a);
    tick(8);
    check_flag(a, ack);
    check_word(16'(events - e0), 16'(ev));
  endtask
  task automatic load_byte(input logic [7:0] d);
    transmit_write_in.data = d;
    transmit_write_in.valid = 1'b1;
    tick(1);
    transmit_write_in.valid = 1'b0;
  endtask
  task automatic release_clock();
    clock_line_release_in = 1'b1;
    tick(1);
    clock_line_release_in = 1'b0;
  endtask
  // master reads one byte; data and one event after the ninth fall
  task automatic take(input logic [7:0] d, input logic ack);
    int e0;
    logic [7:0] got;
    e0 = events;
    i2c_bus_master_model_i.read_byte(ack, got);
    tick(8);
    check_word(16'(got), 16'(d));
    check_word(16'(events - e0), 16'h0001);
  endtask
  task automatic fetch(input logic [7:0] d, input logic ack);
    check_flag(scl_oe_out, 1'b1);
    load_byte(d);
    tick(4);
    check_flag(scl_oe_out, 1'b1);
    check_flag(status_reg_out[STAT_TBF_POS], 1'b1);
    release_clock();
    take(d, ack);
  endtask
  task automatic pop(input logic [7:0] d);
    check_flag(receive_byte_out.valid, 1'b1);
    check_word(16'(receive_byte_out.data), 16'(d));
    receive_ready_in = 1'b1;
    tick(1);
    receive_ready_in = 1'b0;
    tick(1);
  endtask
  initial begin
    #2_000_000;
    miscompares++;
    give_verdict();
  end
  initial begin
    tick(4);
    sys_rst_in = 1'b0;
    tick(6);
    check_word(status_reg_out, 16'h0000);
    send(8'hA4, 1'b0, 0);
    i2c_bus_master_model_i.start_cond();
    send(8'hA4, 1'b1, 1);
    check_flag(receive_byte_out.valid, 1'b0);
    check_flag(status_reg_out[STAT_RBF_POS], 1'b0);
    send(8'hA5, 1'b1, 1);
    send(8'h3C, 1'b1, 1);
    check_flag(status_reg_out[STAT_RBF_POS], 1'b1);
    send(8'h77, 1'b0, 1);
    check_flag(status_reg_out[STAT_OVF_POS], 1'b1);
    i2c_bus_master_model_i.stop_cond();
    pop(8'hA5);
    i2c_bus_master_model_i.start_cond();
    send(8'hA4, 1'b1, 1);
    send(8'h11, 1'b0, 1);
    i2c_bus_master_model_i.stop_cond();
    overflow_clear_in = 1'b1;
    tick(1);
    overflow_clear_in = 1'b0;
    pop(8'h3C);
    pop(8'h11);
    check_flag(receive_byte_out.valid, 1'b0);
    $display("test seven_bit_write done");
    i2c_bus_master_model_i.start_cond();
    send(8'hA6, 1'b0, 0);
    check_flag(sda_oe_out, 1'b0);
    i2c_bus_master_model_i.stop_cond();
    $display("test address_mismatch done");
    i2c_bus_master_model_i.start_cond();
    send(8'hA5, 1'b1, 1);
    check_flag(status_reg_out[STAT_RW_POS], 1'b1);
    fetch(8'hC3, 1'b1);
    // a byte written during the transfer goes out with no stretch
    check_flag(scl_oe_out, 1'b1);
    load_byte(8'h5A);
    release_clock();
    load_byte(8'h3E);
    take(8'h5A, 1'b1);
    check_flag(scl_oe_out, 1'b0);
    check_flag(status_reg_out[STAT_TBF_POS], 1'b0);
    take(8'h3E, 1'b0);
    check_flag(i2c_bus_master_model_i.unstable_seen, 1'b0);
    i2c_bus_master_model_i.stop_cond();
    $display("test seven_bit_read done");
    control_reg_in = 16'h8400;
    own_address_reg_in = 10'h2B6;
    i2c_bus_master_model_i.start_cond();
    send(8'hF4, 1'b1, 1);
    check_flag(status_reg_out[STAT_TEN_POS], 1'b0);
    send(8'hB6, 1'b1, 1);
    check_flag(status_reg_out[STAT_TEN_POS], 1'b1);
    send(8'h42, 1'b1, 1);
    i2c_bus_master_model_i.start_cond();
    send(8'hF5, 1'b1, 1);
    fetch(8'h99, 1'b0);
    i2c_bus_master_model_i.stop_cond();
    pop(8'h42);
    i2c_bus_master_model_i.start_cond();
    send(8'hF2, 1'b0, 0);
    check_flag(status_reg_out[STAT_TEN_POS], 1'b0);
    i2c_bus_master_model_i.stop_cond();
    i2c_bus_master_model_i.start_cond();
    send(8'hF4, 1'b1, 1);
    send(8'hB7, 1'b0, 0);
    check_flag(status_reg_out[STAT_TEN_POS], 1'b0);
    i2c_bus_master_model_i.stop_cond();
    $display("test ten_bit done");
    // module disabled: own seven-bit address is ignored
    control_reg_in = 16'h0000;
    i2c_bus_master_model_i.start_cond();
    send(8'h6C, 1'b0, 0);
    check_flag(sda_oe_out, 1'b0);
    i2c_bus_master_model_i.stop_cond();
    $display("test disabled done");
    give_verdict();
  end
endmodule
